/* rtl/splf_top.sv */
// Purpose: Payload limit checker and transmit framer with AXI4-Lite registers
// Assumes: MAC path and host logic on aclk; tx_done is a one-cycle pulse
// Notes:   Limit, frame choice and queue policy follow the current settings
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`default_nettype none
module splf_top
	import splf_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	output splf_tx_t          tx_pkt,
	output logic              tx_valid,
	input  wire logic         tx_ready,
	input  wire logic         tx_done,
	input  wire logic         tx_done_bcast,
	input  wire splf_rx_t     rx_in,
	output logic              rx_ind_valid,
	output logic [7:0]        rx_ind_type,
	output logic [127:0]      cipher_key,
	output logic              irq
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE} splf_tx_state_t;

	splf_tx_state_t state_ff;
	splf_cfg_t      cfg;
	logic [31:0]    cfg_ff;
	logic [31:0]    key_ff [4];
	logic [7:0]     limit;
	logic [2:0]     sec_level;
	logic [7:0]     aw_addr_ff;
	logic [31:0]    w_data_ff;
	logic [3:0]     w_strb_ff;
	logic           aw_have_ff;
	logic           w_have_ff;
	logic           wr_fire;
	logic           treq_ff;
	logic [8:0]     treq_data_ff;
	logic [15:0]    txstat_ff;
	logic [7:0]     rem_ff;
	logic           req_bcast_ff;
	logic [2:0]     inflight_ff;
	logic           bcast_busy_ff;
	logic           can_issue;
	logic           tx_fire;
	logic [7:0]     chunk;
	logic [EV_W-1:0] irq_st_ff;
	logic [EV_W-1:0] irq_msk_ff;
	logic [EV_W-1:0] ev;
	logic [7:0]     drop_cnt_ff;
	logic           rx_drop;
	logic           reject;
	logic           refused;

	// Settings decoded from the configuration word
	assign cfg.enc_en   = cfg_ff[CFG_ENC_BIT];
	assign cfg.hdr_mode = cfg_ff[CFG_HDR_LSB +: 2];
	assign cfg.api_mode = cfg_ff[CFG_API_BIT];
	assign cfg.src_long = cfg_ff[CFG_SRCL_BIT];
	assign cfg.dst_long = cfg_ff[CFG_DSTL_BIT];
	assign cfg.compat   = cfg_ff[CFG_CMP_LSB +: 8];

	// Merge write data under byte strobes
	function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Address is mapped when it hits one aligned register word
	function automatic logic addr_ok(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= REG_KEY3);
	endfunction

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	splf_limit_calc u_limit (
		.cfg       (cfg),
		.limit     (limit),
		.sec_level (sec_level)
	);

	splf_rx_classify u_rx (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.cfg          (cfg),
		.rx           (rx_in),
		.ind_valid_ff (rx_ind_valid),
		.ind_type_ff  (rx_ind_type),
		.drop_ff      (rx_drop)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign wr_fire = aw_have_ff && w_have_ff && !s_axi_bvalid;

	// Address and data taken in either order, answer after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff    <= 1'b0;
			w_have_ff     <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 32'h0000_0000;
			w_strb_ff     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have_ff && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_have_ff && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_ok(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_have_ff   <= 1'b0;
				w_have_ff    <= 1'b0;
			end
		end
	end

	// Configuration, mask and key registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_ff     <= CFG_RESET;
			irq_msk_ff <= MASK_RESET;
			for (int i = 0; i < 4; i++) begin
				key_ff[i] <= 32'h0000_0000;
			end
		end else if (wr_fire) begin
			if (aw_addr_ff == REG_CFG) begin
				cfg_ff <= apply_strb(cfg_ff, w_data_ff, w_strb_ff) & 32'h0000_FF3F;
			end
			if (aw_addr_ff == REG_IRQ_MSK) begin
				irq_msk_ff <= w_data_ff[EV_W-1:0];
			end
			for (int i = 0; i < 4; i++) begin
				if (aw_addr_ff == REG_KEY0 + 8'(4 * i)) begin
					key_ff[i] <= apply_strb(key_ff[i], w_data_ff, w_strb_ff);
				end
			end
		end
	end

	// Key words drive the cipher key, word 0 in the low bits
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cipher_key <= 128'h0;
		end else begin
			cipher_key <= {key_ff[3], key_ff[2], key_ff[1], key_ff[0]};
		end
	end

	// Transmit request pulse: length in bits 7:0, broadcast in bit 8
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			treq_ff      <= 1'b0;
			treq_data_ff <= 9'h000;
		end else begin
			treq_ff <= wr_fire && (aw_addr_ff == REG_TXREQ);
			if (wr_fire && (aw_addr_ff == REG_TXREQ)) begin
				treq_data_ff <= w_data_ff[TXREQ_BC_BIT:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				REG_CFG:     s_axi_rdata <= cfg_ff;
				REG_LIMIT:   s_axi_rdata <= {21'h0, sec_level, limit};
				REG_TXREQ:   s_axi_rdata <= {23'h0, treq_data_ff};
				REG_TXSTAT:  s_axi_rdata <= {16'h0, txstat_ff};
				REG_RXSTAT:  s_axi_rdata <= {16'h0, drop_cnt_ff, rx_ind_type};
				REG_IRQ_ST:  s_axi_rdata <= {27'h0, irq_st_ff};
				REG_IRQ_MSK: s_axi_rdata <= {27'h0, irq_msk_ff};
				REG_QSTAT:   s_axi_rdata <= {23'h0, bcast_busy_ff, 5'h0, inflight_ff};
				default:     s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Transmit engine
	// ----------------------------------------------------------------
	// Legacy allows one packet in flight; else a queue with broadcast aside
	always_comb begin
		if (cfg.compat[0]) begin
			can_issue = (inflight_ff == 3'h0) && !bcast_busy_ff;
		end else if (req_bcast_ff) begin
			can_issue = !bcast_busy_ff;
		end else begin
			can_issue = inflight_ff < QUEUE_DEPTH;
		end
		chunk = (rem_ff > limit) ? limit : rem_ff;
	end

	assign tx_fire = tx_valid && tx_ready;
	assign reject  = treq_ff && (state_ff == ST_IDLE) && cfg.api_mode
		&& (treq_data_ff[7:0] > limit);
	assign refused = treq_ff && (state_ff != ST_IDLE);

	// Accept, reject or split requests into packets for the MAC
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff     <= ST_IDLE;
			rem_ff       <= 8'h00;
			req_bcast_ff <= 1'b0;
			tx_valid     <= 1'b0;
			tx_pkt       <= '0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (treq_ff && !reject && (treq_data_ff[7:0] != 8'h00)) begin
						rem_ff       <= treq_data_ff[7:0];
						req_bcast_ff <= treq_data_ff[TXREQ_BC_BIT];
						state_ff     <= ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					if (tx_fire) begin
						tx_valid <= 1'b0;
						rem_ff   <= rem_ff - tx_pkt.len;
						if (rem_ff == tx_pkt.len) begin
							state_ff <= ST_IDLE;
						end
					end else if (!tx_valid && can_issue) begin
						tx_valid         <= 1'b1;
						tx_pkt.len       <= chunk;
						tx_pkt.bcast     <= req_bcast_ff;
						tx_pkt.src_long  <= cfg.src_long || cfg.enc_en;
						tx_pkt.sec_level <= sec_level;
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Transmit status frame for an oversize request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txstat_ff <= 16'h0000;
		end else if (reject) begin
			txstat_ff <= {FT_TX_STATUS, ST_TOO_LARGE};
		end
	end

	// Count packets in flight by kind
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			inflight_ff   <= 3'h0;
			bcast_busy_ff <= 1'b0;
		end else begin
			if (tx_fire && tx_pkt.bcast) begin
				bcast_busy_ff <= 1'b1;
			end else if (tx_done && tx_done_bcast) begin
				bcast_busy_ff <= 1'b0;
			end
			case ({tx_fire && !tx_pkt.bcast, tx_done && !tx_done_bcast && inflight_ff != 3'h0})
				2'b10:   inflight_ff <= inflight_ff + 3'h1;
				2'b01:   inflight_ff <= inflight_ff - 3'h1;
				default: inflight_ff <= inflight_ff;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Interrupts and receive statistics
	// ----------------------------------------------------------------
	assign ev[EV_TX_REJECT]  = reject;
	assign ev[EV_TX_REFUSED] = refused;
	assign ev[EV_TX_DONE]    = tx_done;
	assign ev[EV_RX_IND]     = rx_ind_valid;
	assign ev[EV_RX_DROP]    = rx_drop;

	// Sticky status, write one to clear, a new event wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_ff <= '0;
			irq       <= 1'b0;
		end else begin
			if (wr_fire && aw_addr_ff == REG_IRQ_ST) begin
				irq_st_ff <= (irq_st_ff & ~w_data_ff[EV_W-1:0]) | ev;
			end else begin
				irq_st_ff <= irq_st_ff | ev;
			end
			irq <= |(irq_st_ff & irq_msk_ff);
		end
	end

	// Dropped packet counter, saturating
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drop_cnt_ff <= 8'h00;
		end else if (rx_drop && drop_cnt_ff != 8'hFF) begin
			drop_cnt_ff <= drop_cnt_ff + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	oversize_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
		reject |=> txstat_ff == {FT_TX_STATUS, ST_TOO_LARGE} && state_ff == ST_IDLE)
		else $error("oversize request did not yield status frame");
	exact_accept_a: assert property (@(posedge aclk) disable iff (!aresetn)
		treq_ff && state_ff == ST_IDLE && treq_data_ff[7:0] == limit
		&& limit != 8'h00 |=> state_ff == ST_ISSUE)
		else $error("request at the exact limit was not accepted");
	legacy_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg.compat[0] && $rose(tx_valid) |-> $past(inflight_ff) == 3'h0)
		else $error("legacy mode issued with a packet in flight");
	queue_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
		inflight_ff <= QUEUE_DEPTH)
		else $error("unicast queue exceeded its depth");
	enc_src_long_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(tx_valid) && $past(cfg.enc_en) |-> tx_pkt.src_long
		&& tx_pkt.sec_level == SEC_LVL_ENC)
		else $error("encrypted packet sent without long source or level 4");
	chunk_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(tx_valid) |-> tx_pkt.len <= $past(limit) && tx_pkt.len != 8'h00)
		else $error("packet larger than payload limit");
	tx_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_pkt))
		else $error("transmit packet dropped before taken");
	legacy_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg.compat[0] |-> limit == (cfg.enc_en ? LIM_LEG_ENC : LIM_LEG_PLAIN))
		else $error("legacy limit wrong");
	base_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!cfg.compat[0] && !cfg.enc_en && !cfg.src_long && !cfg.dst_long
		&& !has_app_hdr(cfg.hdr_mode) |-> limit == LIM_BASE)
		else $error("base limit wrong");
	enc_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!cfg.compat[0] && cfg.enc_en && !cfg.dst_long && has_app_hdr(cfg.hdr_mode)
		|-> limit == LIM_BASE - RED_HDR_ENC - RED_ADDR - RED_SEC)
		else $error("encrypted limit wrong");
	irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		|(irq_st_ff & irq_msk_ff) |=> irq)
		else $error("unmasked event did not raise interrupt");
	reject_c: cover property (@(posedge aclk) disable iff (!aresetn) reject);
	split_c: cover property (@(posedge aclk) disable iff (!aresetn)
		tx_fire && state_ff == ST_ISSUE && rem_ff != tx_pkt.len);
	legacy_send_c: cover property (@(posedge aclk) disable iff (!aresetn)
		tx_fire && cfg.compat[0]);
endmodule
`default_nettype wire

/* rtl/splf_pkg.sv */
// Purpose: Shared constants and carrier types of the secure payload limit framer
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz aclk
// Notes:   Every offset, the cfg and mask reset values and every payload figure live here
`default_nettype none
package splf_pkg;
	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CFG     = 8'h00;
	localparam logic [7:0] REG_LIMIT   = 8'h04;
	localparam logic [7:0] REG_TXREQ   = 8'h08;
	localparam logic [7:0] REG_TXSTAT  = 8'h0C;
	localparam logic [7:0] REG_RXSTAT  = 8'h10;
	localparam logic [7:0] REG_IRQ_ST  = 8'h14;
	localparam logic [7:0] REG_IRQ_MSK = 8'h18;
	localparam logic [7:0] REG_QSTAT   = 8'h1C;
	localparam logic [7:0] REG_KEY0    = 8'h20;
	localparam logic [7:0] REG_KEY3    = 8'h2C;
	localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
	localparam logic [4:0] MASK_RESET  = 5'h00;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CFG_ENC_BIT   = 0;
	localparam int CFG_HDR_LSB   = 1;
	localparam int CFG_API_BIT   = 3;
	localparam int CFG_SRCL_BIT  = 4;
	localparam int CFG_DSTL_BIT  = 5;
	localparam int CFG_CMP_LSB   = 8;
	localparam int TXREQ_BC_BIT  = 8;
	localparam int EV_TX_REJECT  = 0;
	localparam int EV_TX_REFUSED = 1;
	localparam int EV_TX_DONE    = 2;
	localparam int EV_RX_IND     = 3;
	localparam int EV_RX_DROP    = 4;
	localparam int EV_W          = 5;
	// ----------------------------------------------------------------
	// Payload figures, frame codes, levels
	// ----------------------------------------------------------------
	localparam logic [7:0] LIM_BASE       = 8'h74;
	localparam logic [7:0] LIM_LEG_PLAIN  = 8'h64;
	localparam logic [7:0] LIM_LEG_ENC    = 8'h5F;
	localparam logic [7:0] RED_HDR_PLAIN  = 8'h02;
	localparam logic [7:0] RED_HDR_ENC    = 8'h04;
	localparam logic [7:0] RED_ADDR       = 8'h06;
	localparam logic [7:0] RED_SEC        = 8'h05;
	localparam logic [7:0] FT_RX_LONG     = 8'h80;
	localparam logic [7:0] FT_RX_SHORT    = 8'h81;
	localparam logic [7:0] FT_TX_STATUS   = 8'h89;
	localparam logic [7:0] ST_TOO_LARGE   = 8'h4A;
	localparam logic [2:0] SEC_LVL_PLAIN  = 3'h0;
	localparam logic [2:0] SEC_LVL_ENC    = 3'h4;
	localparam logic [2:0] QUEUE_DEPTH    = 3'h4;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] compat;
		logic       dst_long;
		logic       src_long;
		logic       api_mode;
		logic [1:0] hdr_mode;
		logic       enc_en;
	} splf_cfg_t;
	typedef struct packed {
		logic valid;
		logic enc;
		logic src_long;
		logic hdr_short;
	} splf_rx_t;
	typedef struct packed {
		logic [7:0] len;
		logic       bcast;
		logic       src_long;
		logic [2:0] sec_level;
	} splf_tx_t;
	// Header mode 0 or 3 carries the application header
	function automatic logic has_app_hdr(input logic [1:0] mode);
		return (mode == 2'h0) || (mode == 2'h3);
	endfunction
endpackage
`default_nettype wire

/* rtl/splf_limit_calc.sv */
// Purpose: Computes the maximum payload and security level from the settings
// Assumes: Pure combinational, settings stable in the aclk domain
// Notes:   No integrity field is ever counted
`default_nettype none
module splf_limit_calc
	import splf_pkg::*;
(
	input  wire splf_cfg_t  cfg,
	output logic [7:0]      limit,
	output logic [2:0]      sec_level
);
	logic [7:0] red_hdr;
	logic [7:0] red_src;
	logic [7:0] red_dst;
	logic [7:0] red_sec;

	// Individual reductions; no integrity length term exists
	always_comb begin
		red_hdr = 8'h00;
		if (has_app_hdr(cfg.hdr_mode)) begin
			red_hdr = cfg.enc_en ? RED_HDR_ENC : RED_HDR_PLAIN;
		end
		red_src = (cfg.src_long || cfg.enc_en) ? RED_ADDR : 8'h00;
		red_dst = cfg.dst_long ? RED_ADDR : 8'h00;
		red_sec = cfg.enc_en ? RED_SEC : 8'h00;
	end

	// Legacy mode overrides every other reduction
	always_comb begin
		if (cfg.compat[0]) begin
			limit = cfg.enc_en ? LIM_LEG_ENC : LIM_LEG_PLAIN;
		end else begin
			limit = LIM_BASE - red_hdr - red_src - red_dst - red_sec;
		end
		sec_level = cfg.enc_en ? SEC_LVL_ENC : SEC_LVL_PLAIN;
	end
endmodule
`default_nettype wire

/* rtl/splf_rx_classify.sv */
// Purpose: Chooses the receive indication frame or suppresses received data
// Assumes: rx.valid is a one-cycle pulse from the MAC path on aclk
// Notes:   ind_type_ff updates only on an accepted rx.valid; valid and drop flops every cycle
`default_nettype none
module splf_rx_classify
	import splf_pkg::*;
(
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire splf_cfg_t  cfg,
	input  wire splf_rx_t   rx,
	output logic            ind_valid_ff,
	output logic [7:0]      ind_type_ff,
	output logic            drop_ff
);
	logic [7:0] nxt_type;

	// Frame type from source address kind and header presence
	always_comb begin
		if (!cfg.enc_en || has_app_hdr(cfg.hdr_mode)) begin
			nxt_type = rx.hdr_short ? FT_RX_SHORT : FT_RX_LONG;
		end else begin
			nxt_type = FT_RX_LONG;
		end
	end

	// Register indication or drop on each received packet
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ind_valid_ff <= 1'b0;
			ind_type_ff  <= 8'h00;
			drop_ff      <= 1'b0;
		end else begin
			ind_valid_ff <= rx.valid && (rx.enc == cfg.enc_en);
			drop_ff      <= rx.valid && (rx.enc != cfg.enc_en);
			if (rx.valid && (rx.enc == cfg.enc_en)) begin
				ind_type_ff <= nxt_type;
			end
		end
	end

	// Checks on the receive choice
	rx_suppress_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rx.valid && (rx.enc != cfg.enc_en) |=> !ind_valid_ff && drop_ff)
		else $error("mismatched sender encryption was not suppressed");
	rx_nohdr_type_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rx.valid && rx.enc && cfg.enc_en && !has_app_hdr(cfg.hdr_mode)
		|=> ind_type_ff == FT_RX_LONG)
		else $error("encrypted packet without header not typed long");
	rx_short_type_a: assert property (@(posedge aclk) disable iff (!aresetn)
		rx.valid && !rx.enc && !cfg.enc_en && rx.hdr_short
		|=> ind_valid_ff && ind_type_ff == FT_RX_SHORT)
		else $error("plain short-source packet not typed short");
	rx_drop_c: cover property (@(posedge aclk) disable iff (!aresetn) drop_ff);
endmodule
`default_nettype wire

/* tb/splf_mac_model.sv */
// Purpose: Radio MAC side model taking packets from the framer
// Assumes: One clock, aresetn synchronous active low
// Notes:   Takes a packet every other cycle and reports it done one cycle later
`default_nettype none
module splf_mac_model
	import splf_pkg::*;
(
	input  wire logic      aclk,
	input  wire logic      aresetn,
	input  wire logic      tx_valid,
	input  wire splf_tx_t  tx_pkt,
	output logic           tx_ready,
	output logic           tx_done,
	output logic           tx_done_bcast
);
	// Ready after one cycle of valid, done pulse after each take
	always_ff @(posedge aclk) begin
		tx_ready      <= aresetn && tx_valid && !tx_ready;
		tx_done       <= aresetn && tx_valid && tx_ready;
		tx_done_bcast <= aresetn && tx_valid && tx_ready && tx_pkt.bcast;
	end
endmodule
`default_nettype wire

/* tb/splf_top_tb.sv */
// Purpose: Self-checking bench of the payload limit framer
// Assumes: AXI4-Lite master tasks, MAC model on the far side
// Notes:   Expected limits are computed from the settings
`default_nettype none
module splf_top_tb;
	import splf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic tx_valid, tx_ready, tx_done, tx_done_bcast, rx_ind_valid, irq;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_ind_type;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [127:0] cipher_key;
	splf_tx_t tx_pkt;
	splf_rx_t rx_in = '0;
	int n_errors = 0, samples_checked = 0, cyc = 0;
	splf_top splf_top_i (.*);
	splf_mac_model splf_mac_model_i (.*);
	// Clock and hang guard
	initial forever #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// Bus write, both channels offered together, each released once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// Bus read compared with an expected word
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		rsp = s_axi_rresp;
		chk(s_axi_rdata, e);
		s_axi_rready <= 1'b0;
	endtask
	// Next packet taken by the MAC side
	task automatic pk(input logic [7:0] l, input logic b, input logic s, input logic [2:0] v);
		do @(posedge aclk); while (!(tx_valid && tx_ready));
		chk(32'(tx_pkt), 32'({l, b, s, v}));
	endtask
	// One receive pulse and the indication that follows it
	task automatic rxc(input logic e, input logic s, input logic v, input logic [7:0] t);
		@(posedge aclk);
		rx_in <= '{1'b1, e, 1'b0, s};
		@(posedge aclk);
		rx_in <= '0;
		@(posedge aclk);
		chk(32'({rx_ind_valid, rx_ind_valid ? rx_ind_type : 8'h00}), 32'({v, t}));
	endtask
	// Limit from index bits: 0 enc, 1 header, 2 src long, 3 dst long, 4 legacy
	function automatic logic [31:0] explim(input logic [4:0] i);
		int l;
		l = 116 - (i[1] ? (i[0] ? 4 : 2) : 0) - ((i[2] | i[0]) ? 6 : 0);
		l = l - (i[3] ? 6 : 0) - (i[0] ? 5 : 0);
		if (i[4]) l = i[0] ? 95 : 100;
		return {21'h0, i[0], 2'h0, 8'(l)};
	endfunction
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(REG_CFG, 32'h0);
		rdc(REG_LIMIT, 32'h72);
		for (int i = 0; i < 32; i++) begin
			wr(REG_CFG, {23'h0, i[4], 2'h0, i[3], i[2], 2'h1, i[1], i[0]});
			rdc(REG_LIMIT, explim(5'(i)));
		end
		for (int k = 0; k < 4; k++) wr(8'(REG_KEY0 + 4 * k), 32'h0101_0101 * (k + 1));
		repeat (2) @(posedge aclk);
		for (int k = 0; k < 4; k++) chk(cipher_key[32*k+:32], 32'h0101_0101 * (k + 1));
		wr(REG_IRQ_MSK, 32'h1);
		wr(REG_IRQ_ST, 32'h1F);
		wr(REG_CFG, 32'hC);
		wr(REG_TXREQ, 32'd117);
		rdc(REG_TXSTAT, 32'h894A);
		chk(32'(irq), 32'h1);
		wr(REG_IRQ_ST, 32'h1);
		repeat (3) @(posedge aclk);
		chk(32'(irq), 32'h0);
		wr(REG_TXREQ, 32'd116);
		pk(8'd116, 1'b0, 1'b0, 3'h0);
		wr(REG_CFG, 32'h4);
		wr(REG_TXREQ, 32'd200);
		pk(8'd116, 1'b0, 1'b0, 3'h0);
		pk(8'd84, 1'b0, 1'b0, 3'h0);
		rxc(1'b0, 1'b1, 1'b1, FT_RX_SHORT);
		rxc(1'b0, 1'b0, 1'b1, FT_RX_LONG);
		rxc(1'b1, 1'b1, 1'b0, 8'h00);
		wr(REG_CFG, 32'h5);
		wr(REG_TXREQ, 32'd200);
		pk(8'd105, 1'b0, 1'b1, 3'h4);
		pk(8'd95, 1'b0, 1'b1, 3'h4);
		rxc(1'b1, 1'b1, 1'b1, FT_RX_LONG);
		wr(REG_CFG, 32'h7);
		rxc(1'b1, 1'b1, 1'b1, FT_RX_SHORT);
		rdc(8'h40, 32'h0);
		chk(32'(rsp), 32'(RESP_SLVERR));
		wr(8'h40, 32'h1);
		chk(32'(rsp), 32'(RESP_SLVERR));
		rdc(REG_RXSTAT, 32'h181);
		wr(REG_CFG, 32'h104);
		wr(REG_TXREQ, 32'd150);
		pk(8'd100, 1'b0, 1'b0, 3'h0);
		pk(8'd50, 1'b0, 1'b0, 3'h0);
		wr(REG_CFG, 32'h4);
		wr(REG_TXREQ, 32'h164);
		pk(8'd100, 1'b1, 1'b0, 3'h0);
		rdc(REG_QSTAT, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
